//--- ebrg_params.svh
// Constants for the external bus request and grant block
`ifndef EBRG_PARAMS_SVH
`define EBRG_PARAMS_SVH

// ----------------------------------------------------------------------
// Bus widths
// ----------------------------------------------------------------------
`define EBRG_ADDR_W   14
`define EBRG_DATA_W   24
`define EBRG_SEL_W    5

// ----------------------------------------------------------------------
// Select bit positions inside the select vector
// ----------------------------------------------------------------------
`define EBRG_SEL_PROGRAM    0
`define EBRG_SEL_DATA       1
`define EBRG_SEL_BYTE       2
`define EBRG_SEL_COMPOSITE  3
`define EBRG_SEL_IO         4

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define EBRG_SEL_IDLE     5'h1F
`define EBRG_ADDR_RST     14'h0000
`define EBRG_DATA_RST     24'h000000
`define EBRG_PIN_IDLE     1'h1
`define EBRG_SYNC_RST     2'h3

// ----------------------------------------------------------------------
// Timing: request sampling stages before the grant decision
// ----------------------------------------------------------------------
`define EBRG_SYNC_STAGES  2

`endif

//--- ebrg_pkg.sv
// Types shared by the external bus request and grant block
`include "ebrg_params.svh"

package ebrg_pkg;

  // --------------------------------------------------------------------
  // Bus field types
  // --------------------------------------------------------------------
  typedef logic [`EBRG_ADDR_W-1:0] ebrg_addr_type;
  typedef logic [`EBRG_DATA_W-1:0] ebrg_data_type;
  typedef logic [`EBRG_SEL_W-1:0]  ebrg_sel_type;

  // --------------------------------------------------------------------
  // Bus ownership states, one-hot
  // --------------------------------------------------------------------
  typedef enum logic [1:0] {
    EBRG_OWN     = 2'h1,  // Processor owns the external bus
    EBRG_GRANTED = 2'h2   // Bus handed to the outside master
  } ebrg_state_type;

endpackage : ebrg_pkg

//--- ebrg_sync_if.sv
// Carrier between the request pin and its synchroniser
`timescale 1ns/1ns
`default_nettype none

interface ebrg_sync_if;
  logic pin_n;   // Raw request pin, active low, asynchronous
  logic req;     // Synchronised request, active high

  // Synchroniser side: reads the pin, drives the clean request
  modport sync_side (input pin_n, output req);
  // Arbiter side: supplies the pin, reads the clean request
  modport arb_side  (output pin_n, input req);
endinterface : ebrg_sync_if

`default_nettype wire

//--- ebrg_req_sync.sv
// Two-stage synchroniser for the bus request pin
`timescale 1ns/1ns
`default_nettype none

`include "ebrg_params.svh"

module ebrg_req_sync (
  input  wire logic       i_clk,
  input  wire logic       i_rst,
  ebrg_sync_if.sync_side  sync
);
  import ebrg_pkg::*;

  // ----------------------------------------------------------------------
  // Sampling chain
  // ----------------------------------------------------------------------
  logic [`EBRG_SYNC_STAGES-1:0] chain_q;  // Stage 0 is read by stage 1 only

  // Shift the raw pin through the stages; reset to idle (high)
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      chain_q <= `EBRG_SYNC_RST;
    end else begin
      chain_q <= {chain_q[`EBRG_SYNC_STAGES-2:0], sync.pin_n};
    end
  end

  // Last stage is the clean request, turned active high
  assign sync.req = ~chain_q[`EBRG_SYNC_STAGES-1];

endmodule : ebrg_req_sync

`default_nettype wire

//--- ebrg_bus_arbiter.sv
// External bus request and grant arbiter inside the processor
`timescale 1ns/1ns
`default_nettype none

`include "ebrg_params.svh"

module ebrg_bus_arbiter (
  input  wire logic                   i_clk,
  input  wire logic                   i_rst,
  input  wire logic                   i_ext_bus_request_n,
  input  wire logic                   i_run_on_en,
  input  wire logic                   i_proc_in_reset,
  input  wire logic                   i_ext_access_active,
  input  wire logic                   i_ext_access_needed,
  input  wire logic                   i_byte_memory_dma_needed,
  input  wire ebrg_pkg::ebrg_addr_type i_addr,
  input  wire ebrg_pkg::ebrg_data_type i_data,
  input  wire logic                   i_data_drive,
  input  wire ebrg_pkg::ebrg_sel_type  i_sel_n,
  input  wire logic                   i_rd_n,
  input  wire logic                   i_wr_n,
  output var  logic                   o_bus_granted_n,
  output var  logic                   o_grant_hang_n,
  output var  logic                   o_halt,
  output var  ebrg_pkg::ebrg_addr_type o_addr,
  output var  logic                   o_addr_oe,
  output var  ebrg_pkg::ebrg_data_type o_data,
  output var  logic                   o_data_oe,
  output var  ebrg_pkg::ebrg_sel_type  o_sel_n,
  output var  logic                   o_sel_oe,
  output var  logic                   o_rd_n,
  output var  logic                   o_wr_n,
  output var  logic                   o_strobe_oe
);
  import ebrg_pkg::*;

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  ebrg_sync_if    req_if ();        // Pin to synchroniser carrier
  logic           req_s;            // Clean request, active high
  ebrg_state_type state_q;          // Bus ownership state
  ebrg_state_type state_d;          // Next ownership state
  logic           grant_d;          // Bus given away next cycle
  logic           need_bus;         // Core waits on an external access or byte-memory DMA needs the bus
  logic           halt_d;           // Execution stopped next cycle
  logic           hang_d;           // Hang indicator next cycle

  // ----------------------------------------------------------------------
  // Request synchroniser
  // ----------------------------------------------------------------------
  assign req_if.pin_n = i_ext_bus_request_n;

  ebrg_req_sync u_sync (
    .i_clk (i_clk),
    .i_rst (i_rst),
    .sync  (req_if.sync_side)
  );

  assign req_s = req_if.req;

  // ----------------------------------------------------------------------
  // Ownership decision
  // ----------------------------------------------------------------------
  // Processor reset does not enter here: requests work in reset and boot
  always_comb begin
    state_d = state_q;
    case (state_q)
      EBRG_OWN: begin
        // Wait out any access in flight; grant in the gap between two accesses
        if (req_s && !i_ext_access_active) begin
          state_d = EBRG_GRANTED;
        end
      end
      EBRG_GRANTED: begin
        // Master has let go: take the bus back
        if (!req_s) begin
          state_d = EBRG_OWN;
        end
      end
      default: begin
        state_d = EBRG_OWN;
      end
    endcase
  end

  assign grant_d  = (state_d == EBRG_GRANTED);
  assign need_bus = i_ext_access_needed | i_byte_memory_dma_needed;
  // Stop unless run-on lets the core carry on without the bus
  assign halt_d   = grant_d & (~i_run_on_en | need_bus);
  // Stopped for want of the bus while it is away
  assign hang_d   = grant_d & need_bus;

  // State register
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      state_q <= EBRG_OWN;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------------
  // Grant, halt and hang outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_bus_granted_n <= 1'h1;
      o_grant_hang_n  <= 1'h1;
      o_halt          <= 1'h0;
    end else begin
      o_bus_granted_n <= ~grant_d;
      o_grant_hang_n  <= ~hang_d;
      o_halt          <= halt_d;
    end
  end

  // ----------------------------------------------------------------------
  // External bus drivers
  // ----------------------------------------------------------------------
  // Values always follow the core; enables drop while granted away
  always_ff @(posedge i_clk) begin
    if (i_rst) begin
      o_addr      <= `EBRG_ADDR_RST;
      o_data      <= `EBRG_DATA_RST;
      o_sel_n     <= `EBRG_SEL_IDLE;
      o_rd_n      <= `EBRG_PIN_IDLE;
      o_wr_n      <= `EBRG_PIN_IDLE;
      o_addr_oe   <= 1'h1;
      o_data_oe   <= 1'h0;
      o_sel_oe    <= 1'h1;
      o_strobe_oe <= 1'h1;
    end else begin
      o_addr      <= i_addr;
      o_data      <= i_data;
      o_sel_n     <= i_sel_n;
      o_rd_n      <= i_rd_n;
      o_wr_n      <= i_wr_n;
      o_addr_oe   <= ~grant_d;
      o_data_oe   <= ~grant_d & i_data_drive;
      o_sel_oe    <= ~grant_d;
      o_strobe_oe <= ~grant_d;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  a_grant_on_req: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (state_q == EBRG_OWN && req_s && !i_ext_access_active && !i_run_on_en)
      |=> (!o_bus_granted_n && o_halt))
    else $error("request on idle bus not granted with halt");

  a_float_drivers: assert property (
    @(posedge i_clk) disable iff (i_rst)
    !o_bus_granted_n |-> !(o_addr_oe || o_data_oe || o_sel_oe || o_strobe_oe))
    else $error("bus driver enabled while granted");

  a_run_on_keeps: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (state_q == EBRG_GRANTED && req_s && i_run_on_en && !need_bus)
      |=> (!o_bus_granted_n && !o_halt))
    else $error("run-on mode halted without a bus need");

  a_wait_access: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (state_q == EBRG_OWN && i_ext_access_active)
      |=> (o_bus_granted_n && o_addr_oe))
    else $error("bus granted during an external access");

  a_grant_between: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (state_q == EBRG_OWN && req_s && $fell(i_ext_access_active))
      |=> !o_bus_granted_n)
    else $error("pending request not granted between accesses");

  a_release_bus: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (state_q == EBRG_GRANTED && !req_s)
      |=> (o_bus_granted_n && o_addr_oe && o_sel_oe && !o_halt))
    else $error("bus not returned after request withdrawn");

  a_reset_honour: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (i_proc_in_reset && state_q == EBRG_OWN && req_s && !i_ext_access_active)
      |=> !o_bus_granted_n)
    else $error("request ignored while processor in reset");

  a_hang_raise: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (state_q == EBRG_GRANTED && req_s && need_bus)
      |=> (!o_grant_hang_n && o_halt))
    else $error("hang not raised while stopped needing bus");

  a_hang_clear: assert property (
    @(posedge i_clk) disable iff (i_rst)
    (!o_grant_hang_n && state_q == EBRG_GRANTED && !req_s)
      |=> (o_grant_hang_n && o_bus_granted_n && !o_halt))
    else $error("hang or grant kept after request withdrawn");

  a_sync_delay: assert property (
    @(posedge i_clk) disable iff (i_rst)
    $fell(i_ext_bus_request_n) ##1 !i_ext_bus_request_n |=> req_s)
    else $error("request not seen two cycles after the pin");

endmodule : ebrg_bus_arbiter

`default_nettype wire

//--- ebrg_master_model.sv
// Outside bus master model that borrows the external memory bus
`timescale 1ns/1ns
`default_nettype none

module ebrg_master_model (
  input  wire logic       i_clk,
  input  wire logic       i_start,        // Begin one bus tenure
  input  wire logic [7:0] i_hold,         // Granted cycles to use
  input  wire logic       i_bus_granted_n,
  input  wire logic       i_grant_hang_n,
  output var  logic       o_ext_bus_request_n
);
  logic [7:0] left_q;  // Granted cycles still to use

  initial o_ext_bus_request_n = 1'h1;

  // Request, hold while using the bus, give it back on hang
  always @(negedge i_clk) begin
    if (i_start) begin
      o_ext_bus_request_n <= 1'h0;
      left_q              <= i_hold;
    end else if (!o_ext_bus_request_n && !i_grant_hang_n) begin
      o_ext_bus_request_n <= 1'h1;
    end else if (!o_ext_bus_request_n && !i_bus_granted_n) begin
      left_q <= left_q - 8'h01;
      if (left_q == 8'h01) begin
        o_ext_bus_request_n <= 1'h1;
      end
    end
  end
endmodule : ebrg_master_model

`default_nettype wire

//--- test_external_bus_request_grant.sv
// Self-checking bench for the bus request and grant arbiter
`timescale 1ns/1ns
`default_nettype none

module test_external_bus_request_grant;
  import ebrg_pkg::*;
  logic clk = 1'h0, rst = 1'h1, start = 1'h0, chk = 1'h0;
  logic run_on = 1'h0, in_rst = 1'h0, active = 1'h0, need = 1'h0;
  logic dma = 1'h0, drive = 1'h0, rd = 1'h1, wr = 1'h1;
  logic [7:0] hold = 8'h04;
  ebrg_addr_type addr = 14'h0000, addr_o;
  ebrg_data_type data = 24'h000000, data_o;
  ebrg_sel_type  sel = 5'h1F, sel_o;
  logic req_n, gnt_n, hang_n, halt, a_oe, d_oe, s_oe, t_oe, rd_o, wr_o;
  integer seed = 27, bseed = 27, mismatches = 0, compares = 0, n, it;

  initial forever #4 clk = ~clk;

  ebrg_bus_arbiter u_dut (.i_clk(clk), .i_rst(rst),
    .i_ext_bus_request_n(req_n), .i_run_on_en(run_on),
    .i_proc_in_reset(in_rst), .i_ext_access_active(active),
    .i_ext_access_needed(need), .i_byte_memory_dma_needed(dma),
    .i_addr(addr), .i_data(data), .i_data_drive(drive), .i_sel_n(sel),
    .i_rd_n(rd), .i_wr_n(wr), .o_bus_granted_n(gnt_n),
    .o_grant_hang_n(hang_n), .o_halt(halt), .o_addr(addr_o),
    .o_addr_oe(a_oe), .o_data(data_o), .o_data_oe(d_oe), .o_sel_n(sel_o),
    .o_sel_oe(s_oe), .o_rd_n(rd_o), .o_wr_n(wr_o), .o_strobe_oe(t_oe));

  ebrg_master_model u_master (.i_clk(clk), .i_start(start), .i_hold(hold),
    .i_bus_granted_n(gnt_n), .i_grant_hang_n(hang_n),
    .o_ext_bus_request_n(req_n));

  // Compare one value and count it
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  // Expected stop level while granted: run-on stops only for the bus
  function automatic logic exp_halt(input logic ro, input logic nd);
    return !ro || nd;
  endfunction : exp_halt

  // Count falling edges until grant reaches a level, bounded
  task automatic count_to(input logic v, output integer c);
    c = 0;
    do begin
      @(negedge clk);
      c++;
    end while (gnt_n !== v && c < 20);
  endtask : count_to

  // Print counts and verdict, then stop
  task automatic conclude;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  // Random core bus values; drivers follow grant every cycle
  always @(negedge clk) begin
    if (chk) begin
      check(addr_o, addr);
      check(data_o, data);
      check({sel_o, rd_o, wr_o}, {sel, rd, wr});
      check(a_oe, gnt_n);
      check(s_oe, gnt_n);
      check(t_oe, gnt_n);
      check(d_oe, gnt_n & drive);
    end
    addr  <= 14'($random(bseed));
    data  <= 24'($random(bseed));
    sel   <= 5'($random(bseed));
    drive <= 1'($random(bseed));
    rd    <= 1'($random(bseed));
    wr    <= 1'($random(bseed));
  end

  // Main sequence: tenures with and without hang, in and out of access
  initial begin
    fork
      begin
        #20000;
        mismatches++;
        conclude();
      end
    join_none
    repeat (8) @(negedge clk);
    rst <= 1'h0;
    repeat (3) @(negedge clk);
    chk <= 1'h1;
    for (it = 0; it < 9; it++) begin
      run_on <= 1'($random(seed));
      in_rst <= 1'($random(seed));
      hold   <= 8'h04 + (8'($random(seed)) & 8'h07);
      active <= (it % 3 == 2);
      start  <= 1'h1;
      @(negedge clk);
      start  <= 1'h0;
      if (it % 3 == 2) begin
        // Access underway: grant held off until the gap
        repeat (6) begin
          @(negedge clk);
          check(gnt_n, 1'h1);
        end
        active <= 1'h0;
        count_to(1'h0, n);
        check(n, 1);
      end else begin
        count_to(1'h0, n);
        check(n, 3);
      end
      @(negedge clk);
      check(halt, exp_halt(run_on, 1'h0));
      if (it % 3 != 0) begin
        need <= (it % 3 == 1);
        dma  <= (it % 3 == 2);
        @(negedge clk);
        check(hang_n, 1'h0);
        check(halt, exp_halt(run_on, 1'h1));
      end
      @(posedge req_n);
      count_to(1'h1, n);
      check(n, 3);
      @(negedge clk);
      check(hang_n, 1'h1);
      check(halt, 1'h0);
      need <= 1'h0;
      dma  <= 1'h0;
      $display("test %0d done", it);
    end
    conclude();
  end
endmodule : test_external_bus_request_grant

`default_nettype wire
